// ### logic/rtcal_top.sv
// Calendar clock with alarm match, coherent time readout and interrupt registers
`timescale 1ns/1ps
`default_nettype none

module rtcal_top #(
    parameter int DIV_W = 16
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    output var  logic        alarm_irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    rtcal_pkg::rtcal_cal_t cal_r;
    rtcal_pkg::rtcal_cal_t cal_nxt;
    logic [DIV_W-1:0]      div_r;
    logic [DIV_W-1:0]      div_cnt_r;
    logic [31:0]           setup_date_r;
    logic [31:0]           setup_time_r;
    logic [31:0]           alarm_date_r;
    logic [31:0]           alarm_time_r;
    logic [31:0]           shadow_date_r;
    logic [31:0]           rdata_nxt;
    logic                  held_r;
    logic                  run_r;
    logic                  active_r;
    logic                  noleap_r;
    logic                  match_active_r;
    logic                  raw_irq_r;
    logic                  irq_mask_r;
    logic                  irq_force_r;
    logic                  wait_r;
    logic [31:0]           rdata_r;
    logic                  irq_r;
    rtcal_pkg::rtcal_req_t req;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Launch: first cycle of a request; accept: the edge where waitrequest is low
    assign req       = '{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable};
    wire   launch    = (req.read | req.write) & wait_r;
    wire   wr_acc    = req.write & ~wait_r;
    wire   wr_div    = wr_acc & (req.address == rtcal_pkg::OFF_DIVIDER);
    wire   wr_sdate  = wr_acc & (req.address == rtcal_pkg::OFF_SETUP_DATE);
    wire   wr_stime  = wr_acc & (req.address == rtcal_pkg::OFF_SETUP_TIME);
    wire   wr_ctrl   = wr_acc & (req.address == rtcal_pkg::OFF_CTRL);
    wire   wr_adate  = wr_acc & (req.address == rtcal_pkg::OFF_ALARM_DATE);
    wire   wr_atime  = wr_acc & (req.address == rtcal_pkg::OFF_ALARM_TIME);
    wire   wr_mask   = wr_acc & (req.address == rtcal_pkg::OFF_IRQ_MASK);
    wire   wr_force  = wr_acc & (req.address == rtcal_pkg::OFF_IRQ_FORCE);
    wire   rd_time   = launch & req.read & (req.address == rtcal_pkg::OFF_CUR_TIME);
    wire   rd_date   = launch & req.read & (req.address == rtcal_pkg::OFF_CUR_DATE);

    // Merged control word and one-shot load request
    wire [31:0] ctrl_new = rtcal_pkg::reg_merge({23'h0, noleap_r, 7'h0, run_r}, req.writedata,
                                                req.byteenable, rtcal_pkg::CTRL_RW_MASK);
    wire load_req = wr_ctrl & req.byteenable[0]
                  & req.writedata[rtcal_pkg::CTRL_LOAD_BIT];

    // ------------------------------------------------------------------
    // Second tick and calendar arithmetic
    // ------------------------------------------------------------------
    // Tick once every divider+1 cycles while running
    wire tick = active_r & (div_cnt_r >= div_r);
    wire leap = (cal_r.year[1:0] == 2'b00) & ~noleap_r;
    wire [4:0] dim = rtcal_pkg::days_in_month(cal_r.month, leap);

    // Carry seconds through to years; a load overrides the tick
    always_comb begin
        cal_nxt = cal_r;
        if (load_req) begin
            cal_nxt = rtcal_pkg::unpack_cal(setup_date_r, setup_time_r);
        end else if (tick) begin
            cal_nxt.sec = cal_r.sec + 6'h01;
            if (cal_r.sec >= rtcal_pkg::LAST_SEC_MIN) begin
                cal_nxt.sec = 6'h00;
                cal_nxt.min = cal_r.min + 6'h01;
                if (cal_r.min >= rtcal_pkg::LAST_SEC_MIN) begin
                    cal_nxt.min  = 6'h00;
                    cal_nxt.hour = cal_r.hour + 5'h01;
                    if (cal_r.hour >= rtcal_pkg::LAST_HOUR) begin
                        cal_nxt.hour = 5'h00;
                        // Sunday is zero, Saturday six
                        cal_nxt.dotw = (cal_r.dotw >= rtcal_pkg::LAST_WEEKDAY) ? 3'h0
                                     : cal_r.dotw + 3'h1;
                        cal_nxt.day  = cal_r.day + 5'h01;
                        if (cal_r.day >= dim) begin
                            cal_nxt.day   = 5'h01;
                            cal_nxt.month = cal_r.month + 4'h1;
                            if (cal_r.month >= rtcal_pkg::LAST_MONTH) begin
                                cal_nxt.month = 4'h1;
                                cal_nxt.year  = cal_r.year + 12'h001;
                            end
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Alarm compare
    // ------------------------------------------------------------------
    // A disabled field always agrees, so fewer enables make a recurring alarm
    wire arm = alarm_date_r[rtcal_pkg::ARM_BIT];
    wire [6:0] field_ok = {
        ~alarm_date_r[rtcal_pkg::YEAR_ON_BIT]
            | (alarm_date_r[rtcal_pkg::YEAR_LSB +: 12] == cal_r.year),
        ~alarm_date_r[rtcal_pkg::MONTH_ON_BIT]
            | (alarm_date_r[rtcal_pkg::MONTH_LSB +: 4] == cal_r.month),
        ~alarm_date_r[rtcal_pkg::MDAY_ON_BIT]
            | (alarm_date_r[rtcal_pkg::DAY_LSB +: 5] == cal_r.day),
        ~alarm_time_r[rtcal_pkg::WEEKDAY_ON_BIT]
            | (alarm_time_r[rtcal_pkg::DOTW_LSB +: 3] == cal_r.dotw),
        ~alarm_time_r[rtcal_pkg::HOUR_ON_BIT]
            | (alarm_time_r[rtcal_pkg::HOUR_LSB +: 5] == cal_r.hour),
        ~alarm_time_r[rtcal_pkg::MINUTE_ON_BIT]
            | (alarm_time_r[rtcal_pkg::MIN_LSB +: 6] == cal_r.min),
        ~alarm_time_r[rtcal_pkg::SECOND_ON_BIT]
            | (alarm_time_r[rtcal_pkg::SEC_LSB +: 6] == cal_r.sec)};
    wire match_now = arm & (&field_ok);
    wire irq_nxt   = (raw_irq_r & irq_mask_r) | irq_force_r;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        case (req.address)
            rtcal_pkg::OFF_DIVIDER:    rdata_nxt = 32'(div_r);
            rtcal_pkg::OFF_SETUP_DATE: rdata_nxt = setup_date_r;
            rtcal_pkg::OFF_SETUP_TIME: rdata_nxt = setup_time_r;
            rtcal_pkg::OFF_CTRL:       rdata_nxt = (32'(noleap_r) << rtcal_pkg::CTRL_NOLEAP_BIT)
                                                 | (32'(active_r) << rtcal_pkg::CTRL_ACTIVE_BIT)
                                                 | (32'(run_r) << rtcal_pkg::CTRL_RUN_BIT);
            rtcal_pkg::OFF_ALARM_DATE: rdata_nxt = alarm_date_r
                                                 | (32'(match_active_r)
                                                    << rtcal_pkg::ARM_ACTIVE_BIT);
            rtcal_pkg::OFF_ALARM_TIME: rdata_nxt = alarm_time_r;
            rtcal_pkg::OFF_CUR_DATE:   rdata_nxt = shadow_date_r;
            rtcal_pkg::OFF_CUR_TIME:   rdata_nxt = rtcal_pkg::pack_time(cal_r);
            rtcal_pkg::OFF_RAW_IRQ:    rdata_nxt = 32'(raw_irq_r);
            rtcal_pkg::OFF_IRQ_MASK:   rdata_nxt = 32'(irq_mask_r);
            rtcal_pkg::OFF_IRQ_FORCE:  rdata_nxt = 32'(irq_force_r);
            rtcal_pkg::OFF_IRQ_STATUS: rdata_nxt = 32'(irq_r);
            default:                   rdata_nxt = rtcal_pkg::WORD_RESET;
        endcase
    end

    // ------------------------------------------------------------------
    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_r  <= 1'b1;
            rdata_r <= rtcal_pkg::WORD_RESET;
        end else begin
            wait_r  <= ~launch;
            rdata_r <= launch ? rdata_nxt : rdata_r;
        end
    end

    // ------------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_r        <= DIV_W'(rtcal_pkg::DIVIDER_RESET);
            setup_date_r <= rtcal_pkg::WORD_RESET;
            setup_time_r <= rtcal_pkg::WORD_RESET;
            run_r        <= 1'b0;
            noleap_r     <= 1'b0;
            alarm_date_r <= rtcal_pkg::WORD_RESET;
            alarm_time_r <= rtcal_pkg::WORD_RESET;
            irq_mask_r   <= 1'b0;
            irq_force_r  <= 1'b0;
        end else begin
            if (wr_div)
                div_r <= DIV_W'(rtcal_pkg::reg_merge(32'(div_r), req.writedata,
                                                     req.byteenable, 32'(DIV_W'('1))));
            if (wr_sdate)
                setup_date_r <= rtcal_pkg::reg_merge(setup_date_r, req.writedata,
                                                     req.byteenable, rtcal_pkg::DATE_RW_MASK);
            if (wr_stime)
                setup_time_r <= rtcal_pkg::reg_merge(setup_time_r, req.writedata,
                                                     req.byteenable, rtcal_pkg::TIME_RW_MASK);
            if (wr_ctrl) begin
                run_r    <= ctrl_new[rtcal_pkg::CTRL_RUN_BIT];
                noleap_r <= ctrl_new[rtcal_pkg::CTRL_NOLEAP_BIT];
            end
            if (wr_adate)
                alarm_date_r <= rtcal_pkg::reg_merge(alarm_date_r, req.writedata, req.byteenable,
                                                     rtcal_pkg::ALARM_DATE_RW_MASK);
            if (wr_atime)
                alarm_time_r <= rtcal_pkg::reg_merge(alarm_time_r, req.writedata, req.byteenable,
                                                     rtcal_pkg::ALARM_TIME_RW_MASK);
            if (wr_mask & req.byteenable[0])
                irq_mask_r <= req.writedata[0];
            if (wr_force & req.byteenable[0])
                irq_force_r <= req.writedata[0];
        end
    end

    // ------------------------------------------------------------------
    // Running state, calendar, alarm and snapshot
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_r       <= 1'b0;
            div_cnt_r      <= '0;
            cal_r          <= '0;
            match_active_r <= 1'b0;
            raw_irq_r      <= 1'b0;
            irq_r          <= 1'b0;
            held_r         <= 1'b0;
            shadow_date_r  <= rtcal_pkg::WORD_RESET;
        end else begin
            active_r       <= run_r;
            div_cnt_r      <= (tick | ~active_r) ? '0 : div_cnt_r + 1'b1;
            cal_r          <= cal_nxt;
            match_active_r <= arm;
            raw_irq_r      <= match_now;
            irq_r          <= irq_nxt;
            // Time read freezes the date copy until the date is read
            held_r         <= rd_time | (held_r & ~rd_date);
            if (rd_time | (~held_r & ~rd_date))
                shadow_date_r <= rtcal_pkg::pack_date(cal_r);
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;
    assign alarm_irq       = irq_r;

    // ------------------------------------------------------------------
    // Assertions and cover points
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_load_reads_zero: assert property (launch && req.read
        && req.address == rtcal_pkg::OFF_CTRL
        |=> !avs_readdata[rtcal_pkg::CTRL_LOAD_BIT] && !avs_waitrequest)
        else $error("load bit read back as one");
    a_run_to_active: assert property ($rose(run_r) |=> active_r)
        else $error("running flag did not follow run request");
    a_noleap_feb: assert property (tick && noleap_r
        && cal_r.month == rtcal_pkg::FEBRUARY
        && cal_r.day == 5'h1c && cal_r.hour == 5'h17 && cal_r.min == 6'h3b
        && cal_r.sec == 6'h3b && !load_req |=> cal_r.month == 4'h3 && cal_r.day == 5'h01)
        else $error("february did not end on day 28");
    a_alarm_readback: assert property (launch && req.read
        && req.address == rtcal_pkg::OFF_ALARM_TIME
        |=> avs_readdata == $past(alarm_time_r))
        else $error("alarm time word read back wrongly");
    a_disarmed_quiet: assert property (!arm |=> !raw_irq_r
        ##1 (!match_active_r || arm))
        else $error("raw alarm without global arm");
    a_second_recur: assert property (arm
        && alarm_time_r[rtcal_pkg::SECOND_ON_BIT]
        && alarm_time_r[31:29] == 3'h0 && alarm_date_r[26:24] == 3'h0
        && cal_r.sec == alarm_time_r[5:0] |=> raw_irq_r)
        else $error("second-only alarm did not fire");
    a_raw_tracks_match: assert property (raw_irq_r |-> $past(match_now))
        else $error("raw alarm without match");
    a_masked_status: assert property (1'b1 |=> alarm_irq ==
        (($past(raw_irq_r) & $past(irq_mask_r)) | $past(irq_force_r)))
        else $error("masked status mismatch");
    a_month_range: assert property (active_r
        && cal_r.month >= 4'h1 && cal_r.month <= 4'hc
        && cal_r.day >= 5'h01 |=> cal_r.month >= 4'h1 && cal_r.month <= 4'hc)
        else $error("month left its range");
    a_weekday_wrap: assert property (tick && !load_req && cal_r.dotw == 3'h6
        && cal_r.hour == 5'h17 && cal_r.min == 6'h3b && cal_r.sec == 6'h3b
        |=> cal_r.dotw == 3'h0)
        else $error("weekday did not wrap to zero");
    a_tick_spacing: assert property (tick && div_r == 16'h0003 |=> !tick[*3])
        else $error("tick came early");
    a_date_snapshot: assert property (rd_time
        |=> shadow_date_r == $past(rtcal_pkg::pack_date(cal_r))
        ##1 (held_r || !$past(held_r)))
        else $error("date not captured on time read");

    c_alarm_fires: cover property ($rose(raw_irq_r) ##1 alarm_irq);
    c_load_done:   cover property (load_req ##1 cal_r.sec == setup_time_r[5:0]);
    c_time_date:   cover property (rd_time ##[1:20] rd_date);
    c_forced_irq:  cover property (irq_force_r && !raw_irq_r ##1 alarm_irq);

endmodule : rtcal_top

`default_nettype wire

// ### logic/rtcal_pkg.sv
// Package of constants, types and helpers for the calendar clock register block
//
// What this block does
// - Control word: run request bit 0, running bit 1, self-clearing load bit 4.
// - Control bit 8 forces a non-leap year, giving February 28 days.
// - Alarm date word holds year 23:12, month 11:8, day 4:0, reset zero.
// - Alarm time word holds weekday 26:24, hour 20:16, minute 13:8, second 5:0.
// - Each alarm field has its own compare enable; only enabled fields are compared.
// - Alarm date bit 28 arms all matching; bit 29 reports matching active.
// - Date word shows running year, month one to twelve, day one to thirty-one.
// - Masked status equals raw AND enable, OR force; enable and force reset zero.
// - Second tick divides the clock by sixteen-bit value plus one.
// - Weekday counts zero for Sunday, one for Monday, modulo seven.
// - Fewer enabled fields give a recurring alarm, e.g. once per minute.
package rtcal_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [5:0] OFF_DIVIDER    = 6'h00;
    localparam logic [5:0] OFF_SETUP_DATE = 6'h04;
    localparam logic [5:0] OFF_SETUP_TIME = 6'h08;
    localparam logic [5:0] OFF_CTRL       = 6'h0c;
    localparam logic [5:0] OFF_ALARM_DATE = 6'h10;
    localparam logic [5:0] OFF_ALARM_TIME = 6'h14;
    localparam logic [5:0] OFF_CUR_DATE   = 6'h18;
    localparam logic [5:0] OFF_CUR_TIME   = 6'h1c;
    localparam logic [5:0] OFF_RAW_IRQ    = 6'h20;
    localparam logic [5:0] OFF_IRQ_MASK   = 6'h24;
    localparam logic [5:0] OFF_IRQ_FORCE  = 6'h28;
    localparam logic [5:0] OFF_IRQ_STATUS = 6'h2c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_ACTIVE_BIT = 1;
    localparam int CTRL_LOAD_BIT   = 4;
    localparam int CTRL_NOLEAP_BIT = 8;
    localparam int YEAR_LSB        = 12;
    localparam int MONTH_LSB       = 8;
    localparam int DAY_LSB         = 0;
    localparam int DOTW_LSB        = 24;
    localparam int HOUR_LSB        = 16;
    localparam int MIN_LSB         = 8;
    localparam int SEC_LSB         = 0;
    localparam int MDAY_ON_BIT     = 24;
    localparam int MONTH_ON_BIT    = 25;
    localparam int YEAR_ON_BIT     = 26;
    localparam int ARM_BIT         = 28;
    localparam int ARM_ACTIVE_BIT  = 29;
    localparam int SECOND_ON_BIT   = 28;
    localparam int MINUTE_ON_BIT   = 29;
    localparam int HOUR_ON_BIT     = 30;
    localparam int WEEKDAY_ON_BIT  = 31;

    // ------------------------------------------------------------------
    // Writable-bit masks, reset values and calendar limits
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_RW_MASK       = 32'h0000_0101;
    localparam logic [31:0] DATE_RW_MASK       = 32'h00ff_ff1f;
    localparam logic [31:0] TIME_RW_MASK       = 32'h071f_3f3f;
    localparam logic [31:0] ALARM_DATE_RW_MASK = 32'h17ff_ff1f;
    localparam logic [31:0] ALARM_TIME_RW_MASK = 32'hf71f_3f3f;
    localparam logic [31:0] WORD_RESET         = 32'h0000_0000;
    localparam logic [15:0] DIVIDER_RESET      = 16'h0000;
    localparam logic [5:0]  LAST_SEC_MIN       = 6'h3b;
    localparam logic [4:0]  LAST_HOUR          = 5'h17;
    localparam logic [2:0]  LAST_WEEKDAY       = 3'h6;
    localparam logic [3:0]  LAST_MONTH         = 4'hc;
    localparam logic [3:0]  FEBRUARY           = 4'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [11:0] year;
        logic [3:0]  month;
        logic [4:0]  day;
        logic [2:0]  dotw;
        logic [4:0]  hour;
        logic [5:0]  min;
        logic [5:0]  sec;
    } rtcal_cal_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } rtcal_req_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] reg_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [31:0] rw);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rw;
        return (old & ~m) | (wd & m);
    endfunction : reg_merge

    function automatic logic [31:0] pack_date(input rtcal_cal_t c);
        return (32'(c.year) << YEAR_LSB) | (32'(c.month) << MONTH_LSB) | (32'(c.day) << DAY_LSB);
    endfunction : pack_date

    function automatic logic [31:0] pack_time(input rtcal_cal_t c);
        return (32'(c.dotw) << DOTW_LSB) | (32'(c.hour) << HOUR_LSB)
             | (32'(c.min) << MIN_LSB) | (32'(c.sec) << SEC_LSB);
    endfunction : pack_time

    function automatic rtcal_cal_t unpack_cal(input logic [31:0] d, input logic [31:0] t);
        rtcal_cal_t c;
        c.year  = d[YEAR_LSB +: 12];
        c.month = d[MONTH_LSB +: 4];
        c.day   = d[DAY_LSB +: 5];
        c.dotw  = t[DOTW_LSB +: 3];
        c.hour  = t[HOUR_LSB +: 5];
        c.min   = t[MIN_LSB +: 6];
        c.sec   = t[SEC_LSB +: 6];
        return c;
    endfunction : unpack_cal

    function automatic logic [4:0] days_in_month(input logic [3:0] month, input logic leap);
        case (month)
            4'h4, 4'h6, 4'h9, 4'hb: return 5'h1e;
            4'h2:                   return leap ? 5'h1d : 5'h1c;
            default:                return 5'h1f;
        endcase
    endfunction : days_in_month

endpackage : rtcal_pkg

// ### tb/rtcal_top_bench.sv
// Self-checking bench for the calendar clock register block
`timescale 1ns/1ps
`default_nettype none

module rtcal_top_bench;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, alarm_irq;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    int          err_total, num_checks, cyc, i, n;
    // Register rows: address, write value, expected read-back
    logic [5:0]  ra [9] = '{6'h0c, 6'h10, 6'h14, 6'h24, 6'h28, 6'h18, 6'h1c, 6'h30, 6'h20};
    logic [31:0] rw [9] = '{32'hffff_ffee, 32'h07ff_ffff, 32'hffff_ffff, 32'hffff_ffff,
                            32'h0, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h1};
    logic [31:0] re [9] = '{32'h0000_0100, 32'h07ff_ff1f, 32'hf71f_3f3f, 32'h1,
                            32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    rtcal_top #(.DIV_W(16)) rtcal_top_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .alarm_irq(alarm_irq));

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    // One bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0; avs_read <= 1'b0;
    endtask : bus

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            err_total++;
        end
    endtask : chk

    task automatic rc(input logic [5:0] a, input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask : rc

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        clk = 0; rst_n = 0; avs_read = 0; avs_write = 0; avs_address = 0;
        avs_writedata = 0; avs_byteenable = 4'hf; err_total = 0; num_checks = 0; cyc = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 9; i++) rc(ra[i], 32'h0, "reset value");
        for (i = 0; i < 9; i++) begin
            bus(1'b1, ra[i], rw[i]);
            rc(ra[i], re[i], "row read-back");
        end
        $display("end of test register rows");
        bus(1'b1, 6'h10, 32'h0);
        bus(1'b1, 6'h14, 32'h0); bus(1'b1, 6'h00, 32'h3);
        bus(1'b1, 6'h04, 32'h0083_421c); bus(1'b1, 6'h08, 32'h0617_3b3a);
        bus(1'b1, 6'h0c, 32'h0000_0111);
        rc(6'h0c, 32'h0000_0103, "ctrl running");
        q = '1; i = 0;
        while (q[5:0] !== 6'h00 && i < 40) begin
            bus(1'b0, 6'h1c, 32'h0);
            i++;
        end
        chk("time at rollover", 32'h0, q);
        rc(6'h18, 32'h0083_4301, "date at rollover");
        $display("end of test calendar");
        bus(1'b1, 6'h14, 32'h2000_0005); bus(1'b1, 6'h10, 32'h1012_3000);
        rc(6'h10, 32'h3012_3000, "alarm active");
        rc(6'h20, 32'h1, "raw alarm");
        rc(6'h2c, 32'h1, "masked status");
        chk("irq pin", 32'h1, {31'h0, alarm_irq});
        bus(1'b1, 6'h24, 32'h0);
        rc(6'h2c, 32'h0, "masked off");
        bus(1'b1, 6'h28, 32'h1);
        rc(6'h2c, 32'h1, "forced");
        bus(1'b1, 6'h28, 32'h0); bus(1'b1, 6'h10, 32'h0);
        rc(6'h20, 32'h0, "disarmed raw");
        // Second-only alarm: raw must rise, fall, then rise again a minute later
        bus(1'b1, 6'h14, 32'h1000_0005); bus(1'b1, 6'h10, 32'h1000_0000);
        n = 0;
        for (i = 0; i < 3; i++) begin
            do begin
                bus(1'b0, 6'h20, 32'h0);
                n++;
            end while (q[0] !== !i[0] && n < 400);
        end
        chk("second alarm recurs", 32'h1, {31'h0, n < 400});
        $display("end of test alarm");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("readdata in reset", 32'h0, avs_readdata);
        chk("waitrequest in reset", 32'h1, {31'h0, avs_waitrequest});
        chk("irq pin in reset", 32'h0, {31'h0, alarm_irq});
        rst_n <= 1'b1;
        rc(6'h0c, 32'h0, "ctrl after reset");
        rc(6'h10, 32'h0, "alarm after reset");
        rc(6'h00, 32'h0, "divider after reset");
        $display("end of test mid-run reset");
        close_out();
    end
endmodule : rtcal_top_bench

`default_nettype wire
